/* File: rtl/pplpkg.sv */
/*
 Shared constants and types of the parallel program loader.
 Assumes one 40 MHz clock and no register bus.
*/
package ppl_pkg;

    // ------------------------------------------------------------
    // Load-select patterns and commands
    // ------------------------------------------------------------
    localparam logic [1:0] PPL_SEL_ADDR = 2'h0;
    localparam logic [1:0] PPL_SEL_DATA = 2'h1;
    localparam logic [1:0] PPL_SEL_CMD  = 2'h2;
    localparam logic [7:0] PPL_CMD_ERASE = 8'h80;
    localparam logic [7:0] PPL_CMD_WRFL  = 8'h10;
    localparam logic [7:0] PPL_CMD_RST   = 8'h00;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int PPL_PAGE_WORDS = 32;
    localparam int PPL_PAGE_AW    = 5;
    localparam int PPL_CLK_MHZ    = 40;
    localparam int PPL_ERASE_US   = 50;
    localparam int PPL_ERASE_CYC  = PPL_ERASE_US * PPL_CLK_MHZ;
    localparam logic [11:0] PPL_ERASE_CNT = 12'(PPL_ERASE_CYC);
    localparam logic [11:0] PPL_CNT_RST   = 12'h000;

    typedef enum logic [1:0]
    {
        PPL_IDLE  = 2'b00,
        PPL_ERASE = 2'b01,
        PPL_DONE  = 2'b11
    } ppl_state_t;

endpackage

/* File: rtl/ppl_edge_det.sv */
/*
 Rising-edge detector for a pin that is already synchronous.
 Assumes the input is sampled on ref_clk.
*/
`timescale 1ns/10ps
module ppl_edge_det
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic level,
    output logic      rise
);
    logic levelPrev_r;
    logic levelPrev_nxt;

    always_comb
    begin
        levelPrev_nxt = level;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            levelPrev_r <= 1'b0;
        else
            levelPrev_r <= levelPrev_nxt;
    end

    assign rise = level & ~levelPrev_r;
endmodule

/* File: rtl/parallel_program_loader.sv */
/*
 Parallel programming front end: command, address and data latching,
 chip erase sequencing and page buffer collection.
 Assumes synchronous pins, single clock, flash array outside.
*/
`timescale 1ns/10ps
module parallel_program_loader
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       load_select_hi,
    input  wire logic       load_select_lo,
    input  wire logic       byte_select,
    input  wire logic [7:0] dataIn,
    input  wire logic       load_clock_in,
    input  wire logic       writeStrobe_n,
    input  wire logic       eeprom_preserve_fuse,
    output logic            ready_busy_out,
    output logic [7:0]      command,
    output logic [7:0]      addrLow,
    output logic [7:0]      dataLow,
    output logic            eraseFlash,
    output logic            eraseEeprom,
    output logic            clearLocks,
    output logic            pageWordValid,
    output logic [7:0]      pageWordData,
    output logic [4:0]      pageWordIdx
);
    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic loadRise;
    logic wrPrev_r;
    logic wrPrev_nxt;
    logic wrFall;

    ppl_edge_det uLoadEdge
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .level   (load_clock_in),
        .rise    (loadRise)
    );

    assign wrFall = wrPrev_r & ~writeStrobe_n;

    // ------------------------------------------------------------
    // Latches
    // ------------------------------------------------------------
    logic [1:0]             sel;
    logic [7:0]             command_r, command_nxt;
    logic [7:0]             addrLow_r, addrLow_nxt;
    logic [7:0]             addrHigh_r, addrHigh_nxt;
    logic [7:0]             dataLow_r, dataLow_nxt;
    logic                   eraseArmed_r, eraseArmed_nxt;
    logic                   wrFlash_r, wrFlash_nxt;
    ppl_pkg::ppl_state_t    state_r, state_nxt;
    localparam int PPL_PAGE_WORDS_L = ppl_pkg::PPL_PAGE_WORDS;
    logic [7:0]             pageBuf [PPL_PAGE_WORDS_L];

    assign sel = {load_select_hi, load_select_lo};

    always_comb
    begin
        command_nxt    = command_r;
        addrLow_nxt    = addrLow_r;
        addrHigh_nxt   = addrHigh_r;
        dataLow_nxt    = dataLow_r;
        eraseArmed_nxt = eraseArmed_r;
        wrFlash_nxt    = wrFlash_r;
        wrPrev_nxt     = writeStrobe_n;
        if (wrFall && eraseArmed_r && state_r == ppl_pkg::PPL_IDLE)
            eraseArmed_nxt = 1'b0;
        if (loadRise)
        begin
            case (sel)
                ppl_pkg::PPL_SEL_CMD:
                begin
                    command_nxt = dataIn;
                    eraseArmed_nxt = (dataIn == ppl_pkg::PPL_CMD_ERASE)
                                     && !byte_select;
                    wrFlash_nxt = (dataIn == ppl_pkg::PPL_CMD_WRFL);
                end
                ppl_pkg::PPL_SEL_ADDR:
                begin
                    if (!byte_select)
                        addrLow_nxt = dataIn;
                    else
                        addrHigh_nxt = dataIn;
                end
                ppl_pkg::PPL_SEL_DATA:
                begin
                    if (wrFlash_r)
                        dataLow_nxt = dataIn;
                end
                default:
                begin
                    command_nxt = command_r;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Erase sequencer
    // ------------------------------------------------------------
    logic [11:0]         cnt_r, cnt_nxt;
    logic                ready_r, ready_nxt;
    logic                erFl_r, erFl_nxt;
    logic                erEe_r, erEe_nxt;
    logic                clrLk_r, clrLk_nxt;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        ready_nxt = ready_r;
        erFl_nxt  = 1'b0;
        erEe_nxt  = 1'b0;
        clrLk_nxt = 1'b0;
        case (state_r)
            ppl_pkg::PPL_IDLE:
            begin
                ready_nxt = 1'b1;
                if (wrFall && eraseArmed_r)
                begin
                    state_nxt = ppl_pkg::PPL_ERASE;
                    cnt_nxt   = ppl_pkg::PPL_ERASE_CNT;
                    ready_nxt = 1'b0;
                    erFl_nxt  = 1'b1;
                    erEe_nxt  = !eeprom_preserve_fuse;
                end
            end
            ppl_pkg::PPL_ERASE:
            begin
                ready_nxt = 1'b0;
                if (cnt_r == ppl_pkg::PPL_CNT_RST)
                    state_nxt = ppl_pkg::PPL_DONE;
                else
                    cnt_nxt = cnt_r - 12'h001;
            end
            ppl_pkg::PPL_DONE:
            begin
                clrLk_nxt = 1'b1;
                ready_nxt = 1'b1;
                state_nxt = ppl_pkg::PPL_IDLE;
            end
            default:
            begin
                state_nxt = ppl_pkg::PPL_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Page buffer collection
    // ------------------------------------------------------------
    logic       pwv_r, pwv_nxt;
    logic [7:0] pwd_r, pwd_nxt;
    logic [4:0] pwi_r, pwi_nxt;

    always_comb
    begin
        pwv_nxt = 1'b0;
        pwd_nxt = pwd_r;
        pwi_nxt = pwi_r;
        if (loadRise && sel == ppl_pkg::PPL_SEL_DATA && wrFlash_r)
        begin
            pwv_nxt = 1'b1;
            pwd_nxt = dataIn;
            pwi_nxt = addrLow_r[4:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (pwv_nxt)
            pageBuf[pwi_nxt] <= pwd_nxt;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            command_r    <= ppl_pkg::PPL_CMD_RST;
            addrLow_r    <= 8'h00;
            addrHigh_r   <= 8'h00;
            dataLow_r    <= 8'h00;
            eraseArmed_r <= 1'b0;
            wrFlash_r    <= 1'b0;
            wrPrev_r     <= 1'b1;
            state_r      <= ppl_pkg::PPL_IDLE;
            cnt_r        <= ppl_pkg::PPL_CNT_RST;
            ready_r      <= 1'b1;
            erFl_r       <= 1'b0;
            erEe_r       <= 1'b0;
            clrLk_r      <= 1'b0;
            pwv_r        <= 1'b0;
            pwd_r        <= 8'h00;
            pwi_r        <= 5'h00;
        end
        else
        begin
            command_r    <= command_nxt;
            addrLow_r    <= addrLow_nxt;
            addrHigh_r   <= addrHigh_nxt;
            dataLow_r    <= dataLow_nxt;
            eraseArmed_r <= eraseArmed_nxt;
            wrFlash_r    <= wrFlash_nxt;
            wrPrev_r     <= wrPrev_nxt;
            state_r      <= state_nxt;
            cnt_r        <= cnt_nxt;
            ready_r      <= ready_nxt;
            erFl_r       <= erFl_nxt;
            erEe_r       <= erEe_nxt;
            clrLk_r      <= clrLk_nxt;
            pwv_r        <= pwv_nxt;
            pwd_r        <= pwd_nxt;
            pwi_r        <= pwi_nxt;
        end
    end

    assign ready_busy_out = ready_r;
    assign command        = command_r;
    assign addrLow        = addrLow_r;
    assign dataLow        = dataLow_r;
    assign eraseFlash     = erFl_r;
    assign eraseEeprom    = erEe_r;
    assign clearLocks     = clrLk_r;
    assign pageWordValid  = pwv_r;
    assign pageWordData   = pwd_r;
    assign pageWordIdx    = pwi_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_eraseStart;
        wrFall && eraseArmed_r && state_r == ppl_pkg::PPL_IDLE;
    endsequence

    a_cmd_load: assert property (@(posedge ref_clk)
        disable iff (rst) loadRise && sel == ppl_pkg::PPL_SEL_CMD
        |=> command_r == $past(dataIn))
        else $error("command not latched");
    a_addr_low: assert property (@(posedge ref_clk)
        disable iff (rst) loadRise && sel == ppl_pkg::PPL_SEL_ADDR
        && !byte_select |=> addrLow_r == $past(dataIn))
        else $error("address low not latched");
    a_addr_hold: assert property (@(posedge ref_clk)
        disable iff (rst)
        !loadRise |=> $stable(addrLow_r) && $stable(command_r))
        else $error("loaded values changed without load");
    a_data_load: assert property (@(posedge ref_clk)
        disable iff (rst) loadRise && sel == ppl_pkg::PPL_SEL_DATA
        && wrFlash_r |=> dataLow_r == $past(dataIn) && pageWordValid)
        else $error("data low not latched");
    a_erase_busy: assert property (@(posedge ref_clk)
        disable iff (rst)
        s_eraseStart |=> (!ready_busy_out) [*8])
        else $error("busy not shown on erase");
    a_erase_ee: assert property (@(posedge ref_clk)
        disable iff (rst) s_eraseStart
        |=> eraseFlash && eraseEeprom == !$past(eeprom_preserve_fuse))
        else $error("erase targets wrong");
    a_lock_after: assert property (@(posedge ref_clk)
        disable iff (rst)
        clearLocks |-> $past(state_r) == ppl_pkg::PPL_DONE)
        else $error("locks cleared early");
    a_ready_idle: assert property (@(posedge ref_clk)
        disable iff (rst) state_r == ppl_pkg::PPL_IDLE
        && $past(state_r) == ppl_pkg::PPL_IDLE |-> ready_busy_out)
        else $error("busy while idle");
    a_no_wrfl_data: assert property (@(posedge ref_clk)
        disable iff (rst) loadRise && sel == ppl_pkg::PPL_SEL_CMD
        && dataIn == ppl_pkg::PPL_CMD_ERASE |=> !wrFlash_r)
        else $error("write flash mode wrongly kept");
endmodule

/* File: testbench/ppl_programmer_model.sv */
/*
 Behavioural parallel programmer that drives the loader pins.
 Assumes the loader samples its pins on the rising edge of ref_clk.
*/
`timescale 1ns/10ps
module ppl_programmer_model
(
    input  wire logic       ref_clk,
    input  wire logic       ready_busy_out,
    output logic            load_select_hi,
    output logic            load_select_lo,
    output logic            byte_select,
    output logic [7:0]      dataIn,
    output logic            load_clock_in,
    output logic            writeStrobe_n
);
    initial
    begin
        {load_select_hi, load_select_lo, byte_select} = 3'h0;
        dataIn        = 8'h00;
        load_clock_in = 1'b0;
        writeStrobe_n = 1'b1;
    end

    // Selects and bus, one load pulse; returns while load pulses stand
    task automatic loadByte(input logic [1:0] sel, input logic bs,
                            input logic [7:0] val);
        while (ready_busy_out !== 1'b1) @(negedge ref_clk);
        @(negedge ref_clk);
        {load_select_hi, load_select_lo} = sel;
        byte_select = bs;
        dataIn = val;
        @(negedge ref_clk);
        load_clock_in = 1'b1;
        @(negedge ref_clk);
        load_clock_in = 1'b0;
        dataIn = ~val;
    endtask

    // One low-going strobe; returns while erase pulses stand
    task automatic strobe;
        @(negedge ref_clk);
        writeStrobe_n = 1'b0;
        @(negedge ref_clk);
        writeStrobe_n = 1'b1;
    endtask
endmodule

/* File: testbench/parallel_program_loader_tb.sv */
/*
 Self-checking bench for the parallel program loader.
 Assumes the programmer model drives all loader pins but clock, reset and the fuse.
*/
`timescale 1ns/10ps
module parallel_program_loader_tb;
    typedef struct packed
    {
        logic [1:0] sel;
        logic       bs;
        logic [7:0] din;
        logic [7:0] cmd;
        logic [7:0] adr;
        logic [7:0] dat;
        logic       vld;
    } ppl_row_t;

    logic       ref_clk, rst, eeprom_preserve_fuse;
    logic       load_select_hi, load_select_lo, byte_select;
    logic [7:0] dataIn, command, addrLow, dataLow, pageWordData;
    logic       load_clock_in, writeStrobe_n, ready_busy_out;
    logic       eraseFlash, eraseEeprom, clearLocks, pageWordValid;
    logic [4:0] pageWordIdx;
    int         errTotal, checkCount;
    ppl_row_t   rows [0:7] = '{
        '{2'h2, 1'b0, 8'h10, 8'h10, 8'h00, 8'h00, 1'b0},
        '{2'h0, 1'b0, 8'h00, 8'h10, 8'h00, 8'h00, 1'b0},
        '{2'h1, 1'b0, 8'hA5, 8'h10, 8'h00, 8'hA5, 1'b1},
        '{2'h0, 1'b0, 8'hFF, 8'h10, 8'hFF, 8'hA5, 1'b0},
        '{2'h1, 1'b0, 8'h5A, 8'h10, 8'hFF, 8'h5A, 1'b1},
        '{2'h0, 1'b1, 8'h33, 8'h10, 8'hFF, 8'h5A, 1'b0},
        '{2'h2, 1'b0, 8'h00, 8'h00, 8'hFF, 8'h5A, 1'b0},
        '{2'h1, 1'b0, 8'h77, 8'h00, 8'hFF, 8'h5A, 1'b0}};

    parallel_program_loader dut (.ref_clk, .rst, .load_select_hi,
        .load_select_lo, .byte_select, .dataIn, .load_clock_in,
        .writeStrobe_n, .eeprom_preserve_fuse, .ready_busy_out, .command,
        .addrLow, .dataLow, .eraseFlash, .eraseEeprom, .clearLocks,
        .pageWordValid, .pageWordData, .pageWordIdx);

    ppl_programmer_model prog (.ref_clk, .ready_busy_out, .load_select_hi,
        .load_select_lo, .byte_select, .dataIn, .load_clock_in,
        .writeStrobe_n);

    // ------------------------------------------------------------
    // Clock, compare and closing
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string msg);
        checkCount++;
        if (seen !== exp)
        begin
            $display("wrong value at %0t: %s %h not %h", $time, msg, seen,
                     exp);
            errTotal++;
        end
    endtask

    task automatic reportAndStop;
        $display("comparisons %0d, mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Erase, then count busy cycles until ready returns
    task automatic eraseRun(input logic keep);
        int lowCyc;
        lowCyc = 0;
        eeprom_preserve_fuse = keep;
        prog.loadByte(ppl_pkg::PPL_SEL_CMD, 1'b0, ppl_pkg::PPL_CMD_ERASE);
        check(16'(command), 16'h0080, "erase cmd");
        prog.strobe();
        check(16'(eraseFlash), 16'h0001, "flash erase");
        check(16'(eraseEeprom), 16'(!keep), "eeprom erase");
        check(16'(clearLocks), 16'h0000, "locks early");
        while (ready_busy_out === 1'b0 && lowCyc < 3000)
        begin
            lowCyc++;
            @(negedge ref_clk);
        end
        check(16'(lowCyc), 16'(ppl_pkg::PPL_ERASE_CYC + 2), "busy");
        check(16'(clearLocks), 16'h0001, "locks");
        check(16'(ready_busy_out), 16'h0001, "ready back");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        errTotal = 0;
        checkCount = 0;
        eeprom_preserve_fuse = 1'b0;
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        check(16'(ready_busy_out), 16'h0001, "reset ready");
        check(16'(command), 16'h0000, "reset cmd");
        check({addrLow, dataLow}, 16'h0000, "reset addr data");
        foreach (rows[i])
        begin
            prog.loadByte(rows[i].sel, rows[i].bs, rows[i].din);
            check(16'(command), 16'(rows[i].cmd), "cmd");
            check(16'(addrLow), 16'(rows[i].adr), "addr");
            check(16'(dataLow), 16'(rows[i].dat), "data");
            check(16'(pageWordValid), 16'(rows[i].vld), "valid");
            check(16'(ready_busy_out), 16'h0001, "ready");
            if (rows[i].vld)
            begin
                check(16'(pageWordData), 16'(rows[i].din), "pg");
                check(16'(pageWordIdx), 16'(rows[i].adr[4:0]), "ix");
            end
        end
        eraseRun(1'b0);
        eraseRun(1'b1);
        prog.loadByte(ppl_pkg::PPL_SEL_CMD, 1'b0, ppl_pkg::PPL_CMD_ERASE);
        prog.strobe();
        check(16'(ready_busy_out), 16'h0000, "busy pre reset");
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        check(16'(ready_busy_out), 16'h0001, "ready after reset");
        check(16'(command), 16'h0000, "cmd after reset");
        check(16'(eraseFlash), 16'h0000, "erase after reset");
        prog.loadByte(ppl_pkg::PPL_SEL_CMD, 1'b1, ppl_pkg::PPL_CMD_ERASE);
        prog.strobe();
        check(16'(ready_busy_out), 16'h0001, "bs high erase");
        check(16'(eraseFlash), 16'h0000, "bs high flash");
        prog.loadByte(ppl_pkg::PPL_SEL_CMD, 1'b0, ppl_pkg::PPL_CMD_WRFL);
        prog.strobe();
        check(16'(ready_busy_out), 16'h0001, "wrfl strobe");
        reportAndStop();
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        errTotal++;
        reportAndStop();
    end
endmodule
